// >>> dbm_pkg.sv
// Constants for the dual-bridge motor control register bank
package dbm_pkg;
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 12;
  localparam int ADDR_BITS = 3;
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_CURRENT = 3'h1;
  localparam logic [2:0] ADDR_OFF_TIME = 3'h2;
  localparam logic [2:0] ADDR_IGNORE = 3'h3;
  localparam logic [2:0] ADDR_FALL = 3'h4;
  localparam logic [2:0] ADDR_UNUSED = 3'h5;
  localparam logic [2:0] ADDR_GATE = 3'h6;
  localparam logic [2:0] ADDR_FLAGS = 3'h7;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int FALL_MODE_LSB = 0;
  localparam int OFF_TIME_LSB = 0;
  localparam int FLAG_OVERTEMP = 0;
  localparam int FLAG_OC_A = 1;
  localparam int FLAG_OC_B = 2;
  localparam int FLAG_GF_A = 3;
  localparam int FLAG_GF_B = 4;
  localparam int FLAG_SUPPLY = 5;
  localparam logic [11:0] RST_CONTROL = 12'h000;
  localparam logic [11:0] RST_CURRENT = 12'h0ff;
  localparam logic [11:0] RST_OFF_TIME = 12'h030;
  localparam logic [11:0] RST_IGNORE = 12'h080;
  localparam logic [11:0] RST_FALL = 12'h010;
  localparam logic [11:0] RST_GATE = 12'h000;
  localparam logic [11:0] RST_FLAGS = 12'h000;
  localparam logic [11:0] MASK_CURRENT = 12'h0ff;
  localparam logic [11:0] MASK_FLAGS = 12'h03f;
  localparam int OFF_STEP_NS = 500;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OFF_STEP_CYCLES = (OFF_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0]
  {
    FALL_SLOW = 3'h0,
    FALL_FAST = 3'h2,
    FALL_MIXED = 3'h3,
    FALL_AUTO = 3'h5
  } dbm_fall_type;
  typedef enum logic [1:0]
  {
    CHOP_IDLE = 2'h0,
    CHOP_DRIVE = 2'h1,
    CHOP_DECAY = 2'h2
  } dbm_chop_type;
endpackage

// >>> dbm_regs.sv
// Serial register bank, fault flags and chopping control for two bridges
`timescale 1ns/1ps
module dbm_regs
#(
  parameter int OFF_TIME_BITS = 8
)
(
  input wire logic ref_clk_i, // System clock, 100 MHz
  input wire logic reset_n_i, // Async reset, active low
  input wire logic serial_clk_i, // Link clock from host
  input wire logic serial_select_i, // Frame select, active high
  input wire logic serial_data_in_i, // Host to device data
  output logic serial_data_out_o, // Device to host data
  output logic serial_data_out_oe_o, // Drive enable for data out
  input wire logic sleep_request_low_i, // Sleep pin, low sleeps
  input wire logic overtemp_i, // Die overtemperature level
  input wire logic supply_low_i, // Supply under threshold level
  input wire logic [1:0] overcurrent_i, // Qualified overcurrent per bridge
  input wire logic [1:0] gate_fault_i, // Pre-driver fault per bridge
  input wire logic [1:0] chop_threshold_i, // Winding at chop level per bridge
  output logic pump_enable_o, // Charge pump on
  output logic aux_regulator_enable_o, // Auxiliary regulator on
  output logic [1:0] bridge_run_o, // Bridge may drive
  output logic [1:0] bridge_decay_o, // Bridge in decay phase
  output logic [2:0] decay_mode_o, // Selected decay mode
  output logic [7:0] current_scale_o, // Full-scale current setting
  output logic fault_out_low_o // Fault pin, low on fault
);
  import dbm_pkg::*;

  // Off-time counter is sized from this width, so refuse what it cannot hold
  if (OFF_TIME_BITS < 1 || OFF_TIME_BITS > DATA_BITS)
  begin : gen_bad_off_width
    $error("OFF_TIME_BITS out of range");
  end

  // Reset release
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Link reset held while system reset active
  logic [1:0] lrst_sync;
  logic lrst_n;
  always_ff @(posedge serial_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      lrst_sync <= 2'b00;
    else
      lrst_sync <= {lrst_sync[0], 1'b1};
  end
  assign lrst_n = lrst_sync[1];

  // Link domain: shift frame, toggle on completion
  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] next_shift_in;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [FRAME_BITS-1:0] frame_hold;
  logic [FRAME_BITS-1:0] next_frame_hold;
  logic frame_tgl;
  logic next_frame_tgl;
  logic [DATA_BITS-1:0] rd_shift;
  logic [DATA_BITS-1:0] next_rd_shift;
  logic [DATA_BITS-1:0] rd_word;

  always_comb
  begin
    next_shift_in = shift_in;
    next_bit_cnt = bit_cnt;
    next_frame_hold = frame_hold;
    next_frame_tgl = frame_tgl;
    next_rd_shift = rd_shift;
    if (!serial_select_i)
      next_bit_cnt = 5'h00;
    else
    begin
      next_shift_in = {shift_in[FRAME_BITS-2:0], serial_data_in_i};
      // Load on the first data edge, once every address bit sits in shift_in
      if (bit_cnt == 5'(ADDR_BITS + 1))
        next_rd_shift = rd_word;
      else if (bit_cnt > 5'(ADDR_BITS + 1))
        next_rd_shift = {rd_shift[DATA_BITS-2:0], 1'b0};
      if (bit_cnt == 5'(FRAME_BITS - 1))
      begin
        next_frame_hold = {shift_in[FRAME_BITS-2:0], serial_data_in_i};
        next_frame_tgl = ~frame_tgl;
        next_bit_cnt = 5'h00;
      end
      else
        next_bit_cnt = bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge serial_clk_i or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      shift_in <= '0;
      bit_cnt <= 5'h00;
      frame_hold <= '0;
      frame_tgl <= 1'b0;
      rd_shift <= '0;
    end
    else
    begin
      shift_in <= next_shift_in;
      bit_cnt <= next_bit_cnt;
      frame_hold <= next_frame_hold;
      frame_tgl <= next_frame_tgl;
      rd_shift <= next_rd_shift;
    end
  end

  // Read data, one bit per link edge after the address
  assign serial_data_out_o = rd_shift[DATA_BITS-1];
  assign serial_data_out_oe_o = serial_select_i;

  // Read word chosen combinationally from address bits as they arrive
  logic [ADDR_BITS-1:0] rd_addr;
  logic [DATA_BITS-1:0] reg_mirror [8];
  assign rd_addr = shift_in[ADDR_BITS-1:0];
  assign rd_word = reg_mirror[rd_addr];

  // System domain: synchronise pins and frame toggle
  logic [2:0] tgl_sync;
  logic [1:0] sleep_sync;
  logic [1:0] ot_sync;
  logic [1:0] uv_sync;
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_sync <= 3'h0;
      sleep_sync <= 2'h0;
      ot_sync <= 2'h0;
      uv_sync <= 2'h0;
    end
    else
    begin
      tgl_sync <= {tgl_sync[1:0], frame_tgl};
      sleep_sync <= {sleep_sync[0], sleep_request_low_i};
      ot_sync <= {ot_sync[0], overtemp_i};
      uv_sync <= {uv_sync[0], supply_low_i};
    end
  end

  logic frame_evt;
  logic awake;
  logic overtemp;
  logic supply_low;
  assign frame_evt = tgl_sync[2] ^ tgl_sync[1];
  assign awake = sleep_sync[1];
  assign overtemp = ot_sync[1];
  assign supply_low = uv_sync[1];

  // Frame is stable while the toggle crosses, so it may be sampled here
  logic wr_evt;
  logic [2:0] wr_addr;
  logic [DATA_BITS-1:0] wr_data;
  assign wr_evt = frame_evt && !frame_hold[FRAME_BITS-1];
  assign wr_addr = frame_hold[DATA_BITS +: ADDR_BITS];
  assign wr_data = frame_hold[DATA_BITS-1:0];

  // Register state
  logic [DATA_BITS-1:0] reg_ctrl, next_reg_ctrl;
  logic [DATA_BITS-1:0] reg_cur, next_reg_cur;
  logic [DATA_BITS-1:0] reg_off, next_reg_off;
  logic [DATA_BITS-1:0] reg_ign, next_reg_ign;
  logic [DATA_BITS-1:0] reg_fall, next_reg_fall;
  logic [DATA_BITS-1:0] reg_gate, next_reg_gate;
  logic [5:0] flags, next_flags;

  always_comb
  begin
    next_reg_ctrl = reg_ctrl;
    next_reg_cur = reg_cur;
    next_reg_off = reg_off;
    next_reg_ign = reg_ign;
    next_reg_fall = reg_fall;
    next_reg_gate = reg_gate;
    next_flags = flags;
    if (wr_evt)
    begin
      unique case (wr_addr)
        ADDR_CONTROL: next_reg_ctrl = wr_data;
        ADDR_CURRENT: next_reg_cur = wr_data & MASK_CURRENT;
        ADDR_OFF_TIME: next_reg_off = wr_data;
        ADDR_IGNORE: next_reg_ign = wr_data;
        ADDR_FALL: next_reg_fall = wr_data;
        ADDR_GATE: next_reg_gate = wr_data;
        ADDR_FLAGS:
        begin
          // Zero clears latched overcurrent and gate flags, supply only when awake; ones never set them
          next_flags[FLAG_OC_A] = flags[FLAG_OC_A] & wr_data[FLAG_OC_A];
          next_flags[FLAG_OC_B] = flags[FLAG_OC_B] & wr_data[FLAG_OC_B];
          next_flags[FLAG_GF_A] = flags[FLAG_GF_A] & wr_data[FLAG_GF_A];
          next_flags[FLAG_GF_B] = flags[FLAG_GF_B] & wr_data[FLAG_GF_B];
          if (awake && !supply_low)
            next_flags[FLAG_SUPPLY] = flags[FLAG_SUPPLY] & wr_data[FLAG_SUPPLY];
        end
        default: ; // Reserved slot ignores writes
      endcase
    end
    // Events set after a clear so set wins
    if (overcurrent_i[0]) next_flags[FLAG_OC_A] = 1'b1;
    if (overcurrent_i[1]) next_flags[FLAG_OC_B] = 1'b1;
    if (gate_fault_i[0]) next_flags[FLAG_GF_A] = 1'b1;
    if (gate_fault_i[1]) next_flags[FLAG_GF_B] = 1'b1;
    next_flags[FLAG_OVERTEMP] = overtemp;
    if (supply_low)
      next_flags[FLAG_SUPPLY] = 1'b1;
    else if (awake)
      next_flags[FLAG_SUPPLY] = 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_ctrl <= RST_CONTROL;
      reg_cur <= RST_CURRENT;
      reg_off <= RST_OFF_TIME;
      reg_ign <= RST_IGNORE;
      reg_fall <= RST_FALL;
      reg_gate <= RST_GATE;
      flags <= RST_FLAGS[5:0];
    end
    else
    begin
      reg_ctrl <= next_reg_ctrl;
      reg_cur <= next_reg_cur;
      reg_off <= next_reg_off;
      reg_ign <= next_reg_ign;
      reg_fall <= next_reg_fall;
      reg_gate <= next_reg_gate;
      flags <= next_flags;
    end
  end

  // Read view; crosses unsynchronised but a host reads after settling
  assign reg_mirror[ADDR_CONTROL] = reg_ctrl;
  assign reg_mirror[ADDR_CURRENT] = reg_cur & MASK_CURRENT;
  assign reg_mirror[ADDR_OFF_TIME] = reg_off;
  assign reg_mirror[ADDR_IGNORE] = reg_ign;
  assign reg_mirror[ADDR_FALL] = reg_fall;
  assign reg_mirror[ADDR_UNUSED] = '0;
  assign reg_mirror[ADDR_GATE] = reg_gate;
  assign reg_mirror[ADDR_FLAGS] = {6'h00, flags};

  // Power and bridge gating
  logic all_off;
  assign all_off = !awake || flags[FLAG_OVERTEMP] || flags[FLAG_SUPPLY];
  assign pump_enable_o = awake;
  assign aux_regulator_enable_o = awake;
  assign current_scale_o = reg_cur[7:0];
  assign decay_mode_o = reg_fall[FALL_MODE_LSB +: 3];

  logic [1:0] bridge_ok;
  assign bridge_ok[0] = !all_off && reg_ctrl[CTRL_ENABLE_BIT]
    && !flags[FLAG_OC_A] && !flags[FLAG_GF_A];
  assign bridge_ok[1] = !all_off && reg_ctrl[CTRL_ENABLE_BIT]
    && !flags[FLAG_OC_B] && !flags[FLAG_GF_B];

  // Chopping per bridge: drive until threshold, decay for off time
  logic [OFF_TIME_BITS-1:0] off_steps;
  assign off_steps = reg_off[OFF_TIME_LSB +: OFF_TIME_BITS];
  logic [1:0] run_q;
  logic [1:0] decay_q;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_chop
      dbm_chop_type st, next_st;
      logic [OFF_TIME_BITS+7:0] cnt, next_cnt;
      always_comb
      begin
        next_st = st;
        next_cnt = cnt;
        unique case (st)
          CHOP_IDLE:
            if (bridge_ok[g])
              next_st = CHOP_DRIVE;
          CHOP_DRIVE:
            if (!bridge_ok[g])
              next_st = CHOP_IDLE;
            else if (chop_threshold_i[g])
            begin
              next_st = CHOP_DECAY;
              next_cnt = (OFF_TIME_BITS + 8)'((off_steps + 1) * OFF_STEP_CYCLES);
            end
          CHOP_DECAY:
            if (!bridge_ok[g])
              next_st = CHOP_IDLE;
            else if (cnt <= 1)
              next_st = CHOP_DRIVE;
            else
              next_cnt = cnt - 1'b1;
          default: next_st = CHOP_IDLE;
        endcase
      end
      always_ff @(posedge ref_clk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          st <= CHOP_IDLE;
          cnt <= '0;
        end
        else
        begin
          st <= next_st;
          cnt <= next_cnt;
        end
      end
      assign run_q[g] = (st != CHOP_IDLE);
      assign decay_q[g] = (st == CHOP_DECAY);
    end
  endgenerate

  assign bridge_run_o = run_q & bridge_ok;
  assign bridge_decay_o = decay_q & bridge_ok;
  // Pin stays low while any flag stands, so release waits for recovery
  assign fault_out_low_o = (flags == 6'h00);

  // Checks
  chk_sleep_gates: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !awake |-> (bridge_run_o == 2'b00 && !pump_enable_o))
    else $error("bridge runs in sleep");
  chk_oc_stops: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    overcurrent_i[0] |=> (flags[FLAG_OC_A] && !bridge_run_o[0] && !fault_out_low_o))
    else $error("overcurrent not latched");
  chk_gf_stops: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    gate_fault_i[1] |=> (flags[FLAG_GF_B] && !bridge_run_o[1]))
    else $error("gate fault not latched");
  chk_fault_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    fault_out_low_o |-> (flags == 6'h00))
    else $error("fault pin released with flag set");
  chk_disable_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !reg_ctrl[CTRL_ENABLE_BIT] |-> bridge_run_o == 2'b00)
    else $error("bridge runs while disabled");
  chk_uv_sleep: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (flags[FLAG_SUPPLY] && !awake) |=> flags[FLAG_SUPPLY])
    else $error("supply flag cleared in sleep");
  chk_ot_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $fell(overtemp) |=> !flags[FLAG_OVERTEMP])
    else $error("overtemp flag stuck");
  sequence s_hit;
    gen_chop[0].st == CHOP_DRIVE && bridge_ok[0] && chop_threshold_i[0];
  endsequence
  chk_decay_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    s_hit |=> (gen_chop[0].st == CHOP_DECAY) [*2])
    else $error("decay too short");
  chk_torque_rsvd: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    reg_cur[11:8] == 4'h0)
    else $error("reserved current bits set");
  // Flag clearing by write, automatic recovery, and overtemperature stop
  chk_flag_write_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (wr_evt && wr_addr == ADDR_FLAGS && !wr_data[FLAG_OC_A] && !overcurrent_i[0]) |=> !flags[FLAG_OC_A])
    else $error("zero write left flag set");
  chk_supply_auto: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (flags[FLAG_SUPPLY] && !supply_low && awake) |=> !flags[FLAG_SUPPLY])
    else $error("supply flag did not recover");
  chk_ot_stops: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    flags[FLAG_OVERTEMP] |-> bridge_run_o == 2'b00)
    else $error("bridge runs in overtemperature");
endmodule

// >>> dbm_host.sv
// Host-side serial link master model for the register bank
`timescale 1ns/1ps
module dbm_host
(
  output logic serial_clk_o, // Link clock, still between frames
  output logic serial_select_o, // Frame select, active high
  output logic serial_data_in_o, // Host to device data
  input wire logic serial_data_out_i, // Device to host data
  input wire logic serial_data_out_oe_i // Device drives data out
);
  initial
  begin
    serial_clk_o = 1'b0;
    serial_select_o = 1'b0;
    serial_data_in_o = 1'b0;
  end
  // Clock edges with select low, used around reset only
  task automatic pulse_clocks(input int n);
    repeat (n)
    begin
      #62.5 serial_clk_o = 1'b1;
      #62.5 serial_clk_o = 1'b0;
    end
  endtask
  task automatic frame(input logic rw, input logic [2:0] addr, input logic [11:0] data,
                       output logic [11:0] rdata);
    logic [15:0] word;
    word = {rw, addr, data};
    rdata = 12'h000;
    #20 serial_select_o = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      serial_data_in_o = word[i];
      #62.5 serial_clk_o = 1'b1;
      #62.5 serial_clk_o = 1'b0;
      // Sampled half a period after the rise, data changes only on rises
      if (rw && i <= 11)
      begin
        rdata[i] = serial_data_out_oe_i ? serial_data_out_i : 1'bx;
      end
    end
    #20 serial_select_o = 1'b0;
    // Released line must not keep looking like valid data
    serial_data_in_o = ~serial_data_in_o;
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the dual-bridge register bank
`timescale 1ns/1ps
module testbench;
  import dbm_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sleep_request_low = 1'b1;
  logic overtemp = 1'b0;
  logic supply_low = 1'b0;
  logic [1:0] overcurrent = 2'h0;
  logic [1:0] gate_fault = 2'h0;
  logic [1:0] chop_threshold = 2'h0;
  wire logic serial_clk;
  wire logic serial_select;
  wire logic serial_data_in;
  wire logic serial_data_out;
  wire logic serial_data_out_oe;
  wire logic pump_enable;
  wire logic aux_regulator_enable;
  wire logic fault_out_low;
  wire logic [1:0] bridge_run;
  wire logic [1:0] bridge_decay;
  wire logic [2:0] decay_mode;
  wire logic [7:0] current_scale;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 32'h9f5a;
  logic [11:0] rst_tab [8] = '{RST_CONTROL, RST_CURRENT, RST_OFF_TIME, RST_IGNORE,
                               RST_FALL, 12'h000, RST_GATE, RST_FLAGS};
  dbm_fall_type modes [4] = '{FALL_SLOW, FALL_FAST, FALL_MIXED, FALL_AUTO};
  logic [11:0] d;
  logic [7:0] cur;
  int n;
  int ex;
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  dbm_host host (.serial_clk_o(serial_clk), .serial_select_o(serial_select),
    .serial_data_in_o(serial_data_in), .serial_data_out_i(serial_data_out),
    .serial_data_out_oe_i(serial_data_out_oe));
  dbm_regs uut (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .serial_clk_i(serial_clk),
    .serial_select_i(serial_select), .serial_data_in_i(serial_data_in),
    .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(serial_data_out_oe),
    .sleep_request_low_i(sleep_request_low), .overtemp_i(overtemp),
    .supply_low_i(supply_low), .overcurrent_i(overcurrent), .gate_fault_i(gate_fault),
    .chop_threshold_i(chop_threshold), .pump_enable_o(pump_enable),
    .aux_regulator_enable_o(aux_regulator_enable), .bridge_run_o(bridge_run),
    .bridge_decay_o(bridge_decay), .decay_mode_o(decay_mode),
    .current_scale_o(current_scale), .fault_out_low_o(fault_out_low));
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check_reg(input logic [11:0] got, input logic [11:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: %s read %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: %s pins %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic settle;
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [11:0] v);
    logic [11:0] unused;
    host.frame(1'b0, a, v, unused);
    settle();
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [11:0] exp);
    logic [11:0] got;
    host.frame(1'b1, a, 12'($random(seed)), got);
    check_reg(got, exp, "register");
    settle();
  endtask
  // Run state as one nibble: pump, regulator, both bridges
  function automatic logic [7:0] run_pins();
    return {4'h0, pump_enable, aux_regulator_enable, bridge_run};
  endfunction
  function automatic logic [11:0] expect_reg(input logic [2:0] a, input logic [11:0] v);
    if (a == ADDR_CURRENT)
      return v & MASK_CURRENT;
    if (a == ADDR_UNUSED || a == ADDR_FLAGS)
      return 12'h000;
    return v;
  endfunction
  task automatic wait_decay(input int b, input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (bridge_decay[b] !== lvl && cnt < bound)
    begin
      @(negedge ref_clk);
      cnt++;
    end
    if (cnt >= bound)
    begin
      bad_count++;
      $display("Error %0t: decay wait ran out", $time);
      final_report();
    end
  endtask
  initial
  begin
    // Link side needs its own edges after reset goes high
    host.pulse_clocks(2);
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    host.pulse_clocks(3);
    settle();
    for (int a = 0; a < 8; a++)
      rd_chk(3'(a), rst_tab[a]);
    check_pin(current_scale, 8'hff, "scale");
    check_pin({7'h0, fault_out_low}, 8'h01, "fault");
    repeat (2)
    begin
      for (int a = 0; a < 8; a++)
      begin
        d = 12'($random(seed));
        wr(3'(a), d);
        rd_chk(3'(a), expect_reg(3'(a), d));
        if (a == 1)
          cur = d[7:0];
      end
    end
    check_pin(current_scale, cur, "scale");
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_FALL, {9'h0, modes[m]});
      check_pin({5'h0, decay_mode}, {5'h0, modes[m]}, "decay mode");
    end
    wr(ADDR_CONTROL, 12'h000);
    check_pin(run_pins(), 8'h0c, "enable off");
    rd_chk(ADDR_CURRENT, {4'h0, cur});
    wr(ADDR_CONTROL, 12'h001);
    check_pin(run_pins(), 8'h0f, "enable on");
    supply_low = 1'b1;
    settle();
    rd_chk(ADDR_FLAGS, 12'h020);
    check_pin({7'h0, fault_out_low}, 8'h00, "supply fault");
    supply_low = 1'b0;
    settle();
    check_pin(run_pins(), 8'h0f, "supply back");
    rd_chk(ADDR_FLAGS, 12'h000);
    sleep_request_low = 1'b0;
    settle();
    check_pin(run_pins(), 8'h00, "asleep");
    // Lockout seen only in sleep keeps its flag until wake
    supply_low = 1'b1;
    settle();
    supply_low = 1'b0;
    settle();
    wr(ADDR_FLAGS, 12'h000);
    rd_chk(ADDR_FLAGS, 12'h020);
    sleep_request_low = 1'b1;
    settle();
    check_pin(run_pins(), 8'h0f, "awake");
    wr(ADDR_FLAGS, 12'h000);
    rd_chk(ADDR_FLAGS, 12'h000);
    check_pin({7'h0, fault_out_low}, 8'h01, "fault released");
    overtemp = 1'b1;
    settle();
    wr(ADDR_FLAGS, 12'h000);
    rd_chk(ADDR_FLAGS, 12'h001);
    check_pin({6'h0, fault_out_low, bridge_run[0]}, 8'h00, "overtemp");
    overtemp = 1'b0;
    settle();
    rd_chk(ADDR_FLAGS, 12'h000);
    check_pin({5'h0, fault_out_low, bridge_run}, 8'h07, "overtemp gone");
    // Overcurrent A, B then gate fault A, B
    for (int k = 0; k < 4; k++)
    begin
      if (k < 2)
        overcurrent[k] = 1'b1;
      else
        gate_fault[k - 2] = 1'b1;
      @(negedge ref_clk);
      overcurrent = 2'h0;
      gate_fault = 2'h0;
      settle();
      rd_chk(ADDR_FLAGS, 12'h001 << (k + 1));
      check_pin({5'h0, fault_out_low, bridge_run}, {6'h0, 2'(k % 2 == 0 ? 2 : 1)},
        "bridge stop");
      wr(ADDR_FLAGS, 12'hfff);
      rd_chk(ADDR_FLAGS, 12'h001 << (k + 1));
      wr(ADDR_FLAGS, 12'h000);
      rd_chk(ADDR_FLAGS, 12'h000);
      check_pin({5'h0, fault_out_low, bridge_run}, 8'h07, "bridge resume");
    end
    for (int b = 0; b < 2; b++)
    begin
      d = 12'($random(seed)) & 12'h003;
      wr(ADDR_OFF_TIME, d);
      ex = (int'(d) + 1) * OFF_STEP_CYCLES;
      chop_threshold[b] = 1'b1;
      @(negedge ref_clk);
      chop_threshold = 2'h0;
      wait_decay(b, 1'b1, 20, n);
      wait_decay(b, 1'b0, 2000, n);
      check_pin({7'h0, 1'(n >= ex - 3 && n <= ex + 3)}, 8'h01, "off time");
    end
    final_report();
  end
endmodule
